// ### wdt_ops_pkg.sv
// Constants and types shared by the pre-clear and complement logic
package wdt_ops_pkg;
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned ADDR_W    = 8;
	localparam int unsigned MEM_DEPTH = 256;
	localparam logic        FLAG_RST  = 1'b0;
	localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;

	// Which pre-clear variant ran last
	typedef enum logic [1:0] {LAST_NONE, LAST_FIRST, LAST_SECOND} last_t;

	// Read-modify-write sequencer of the complement
	typedef enum logic [1:0] {CPL_IDLE, CPL_WRITE} cpl_state_t;
endpackage

// ### wdt_data_mem.sv
// Single-port data memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module wdt_data_mem
	import wdt_ops_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_we,
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	output logic      [DATA_W-1:0] o_rdata
);
	logic [DATA_W-1:0] mem [MEM_DEPTH];

	////////////////////////////////////////////////////////////////////////////////
	// Write port
	always_ff @(posedge i_clk)
	begin
		if (i_we)
		begin
			mem[i_addr] <= i_wdata;
		end
	end

	// Read port, data one cycle after the address
	always_ff @(posedge i_clk)
	begin
		o_rdata <= mem[i_addr];
	end
endmodule // wdt_data_mem
`default_nettype wire

// ### wdt_preclear_cpl.sv
// Watchdog pre-clear pair and data-memory complement execution
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RULE_01] An effective pre-clear resets the watchdog counter and clears both status flags; a flag whose event arrives in the same cycle is set instead.
// [RULE_02] First variant acts only if the pair's last executed was the second.
// [RULE_03] Second variant acts only if the pair's last executed was the first.
// [RULE_04] Repeating one variant without the other changes nothing.
// [RULE_05] Complement inverts every bit of the addressed data byte.
// [RULE_06] Complement writes back in place; zero flag set when result is zero.
module wdt_preclear_cpl
	import wdt_ops_pkg::*;
(
	input  wire logic              i_clk,
	input  wire logic              i_rst_n,
	input  wire logic              i_preclear_first,
	input  wire logic              i_preclear_second,
	input  wire logic              i_timeout_event,
	input  wire logic              i_powerdown_event,
	output logic                   o_watchdog_clear,
	output logic                   o_timeout_status_flag,
	output logic                   o_powerdown_status_flag,
	input  wire logic              i_cpl_valid,
	input  wire logic [ADDR_W-1:0] i_cpl_addr,
	output logic                   o_cpl_ready,
	output logic                   o_cpl_done,
	output logic                   o_zero_flag,
	input  wire logic              i_mem_we,
	input  wire logic [ADDR_W-1:0] i_mem_addr,
	input  wire logic [DATA_W-1:0] i_mem_wdata,
	output logic      [DATA_W-1:0] o_mem_rdata
);
	last_t             last_q;
	cpl_state_t        state_q;
	logic [ADDR_W-1:0] addr_q;
	logic              first_go;
	logic              second_go;
	logic              preclear_hit;
	logic              cpl_take;
	logic              mem_we;
	logic [ADDR_W-1:0] mem_addr;
	logic [DATA_W-1:0] mem_wdata;
	logic [DATA_W-1:0] mem_rdata;

	// Ones' complement of a data byte
	function automatic logic [DATA_W-1:0] invert(input logic [DATA_W-1:0] v);
		invert = ~v;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Pre-clear decode; both at once counts as neither
	assign first_go  = i_preclear_first & ~i_preclear_second;
	assign second_go = i_preclear_second & ~i_preclear_first;
	// [RULE_02] first needs second before
	// [RULE_03] second needs first before
	// [RULE_04] repeats leave state alone
	assign preclear_hit = (first_go & (last_q == LAST_SECOND))
		| (second_go & (last_q == LAST_FIRST));

	// Tracks the variant executed last
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			last_q <= LAST_NONE;
		end
		else if (first_go)
		begin
			last_q <= LAST_FIRST;
		end
		else if (second_go)
		begin
			last_q <= LAST_SECOND;
		end
	end

	// [RULE_01] counter clear pulse
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_watchdog_clear <= 1'b0;
		end
		else
		begin
			o_watchdog_clear <= preclear_hit;
		end
	end

	// [RULE_01] flag clear, new event wins
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_timeout_status_flag   <= FLAG_RST;
			o_powerdown_status_flag <= FLAG_RST;
		end
		else
		begin
			if (i_timeout_event)
				o_timeout_status_flag <= 1'b1;
			else if (preclear_hit)
				o_timeout_status_flag <= 1'b0;
			if (i_powerdown_event)
				o_powerdown_status_flag <= 1'b1;
			else if (preclear_hit)
				o_powerdown_status_flag <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Complement sequencer: read, then write back
	assign o_cpl_ready = (state_q == CPL_IDLE);
	assign cpl_take    = i_cpl_valid & o_cpl_ready;

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_q <= CPL_IDLE;
			addr_q  <= ADDR_ZERO;
		end
		else
		begin
			case (state_q)
				CPL_IDLE:
				begin
					if (cpl_take)
					begin
						state_q <= CPL_WRITE;
						addr_q  <= i_cpl_addr;
					end
				end
				CPL_WRITE: state_q <= CPL_IDLE;
				default:   state_q <= CPL_IDLE;
			endcase
		end
	end

	// Memory port steering
	// [RULE_05] inverted byte written
	// [RULE_06] back to the same location
	always_comb
	begin
		if (state_q == CPL_WRITE)
		begin
			mem_we    = 1'b1;
			mem_addr  = addr_q;
			mem_wdata = invert(mem_rdata);
		end
		else if (cpl_take)
		begin
			mem_we    = 1'b0;
			mem_addr  = i_cpl_addr;
			mem_wdata = i_mem_wdata;
		end
		else
		begin
			mem_we    = i_mem_we;
			mem_addr  = i_mem_addr;
			mem_wdata = i_mem_wdata;
		end
	end

	// [RULE_06] zero flag and done pulse
	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			o_zero_flag <= FLAG_RST;
			o_cpl_done  <= 1'b0;
		end
		else
		begin
			o_cpl_done <= (state_q == CPL_WRITE);
			if (state_q == CPL_WRITE)
				o_zero_flag <= (invert(mem_rdata) == DATA_ZERO);
		end
	end

	assign o_mem_rdata = mem_rdata;

	wdt_data_mem u_mem (
		.i_clk   (i_clk),
		.i_we    (mem_we),
		.i_addr  (mem_addr),
		.i_wdata (mem_wdata),
		.o_rdata (mem_rdata)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	a_first_takes_effect: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_02]
		(first_go && last_q == LAST_SECOND && !i_timeout_event && !i_powerdown_event)
		|=> (o_watchdog_clear && !o_timeout_status_flag && !o_powerdown_status_flag))
		else $error("first pre-clear after second did not clear");

	a_second_takes_effect: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_03]
		(second_go && last_q == LAST_FIRST && !i_timeout_event && !i_powerdown_event)
		|=> (o_watchdog_clear && !o_timeout_status_flag && !o_powerdown_status_flag))
		else $error("second pre-clear after first did not clear");

	a_clear_needs_pair: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_01]
		o_watchdog_clear |-> ($past(first_go) && $past(last_q) == LAST_SECOND)
		|| ($past(second_go) && $past(last_q) == LAST_FIRST))
		else $error("watchdog clear without alternation");

	a_repeat_no_effect: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_04]
		((first_go && last_q == LAST_FIRST) || (second_go && last_q == LAST_SECOND))
		|=> (!o_watchdog_clear
			&& (o_timeout_status_flag
				== ($past(o_timeout_status_flag) || $past(i_timeout_event)))
			&& (o_powerdown_status_flag
				== ($past(o_powerdown_status_flag) || $past(i_powerdown_event)))))
		else $error("repeated pre-clear had an effect");

	a_cpl_inverts: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_05]
		cpl_take ##1 1'b1 |-> (mem_we && mem_wdata == ~mem_rdata))
		else $error("complement did not invert the byte");

	a_cpl_same_addr: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_06]
		cpl_take |=> (mem_addr == $past(i_cpl_addr) ##1 o_cpl_done))
		else $error("complement wrote elsewhere or no done");

	a_zero_flag_value: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_06]
		(state_q == CPL_WRITE) |=> (o_zero_flag == ($past(mem_rdata) == ~DATA_ZERO)))
		else $error("zero flag wrong after complement");

	a_flag_event_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_01]
		i_timeout_event |=> o_timeout_status_flag)
		else $error("timeout event lost");

	a_pd_event_wins: assert property (@(posedge i_clk) disable iff (!i_rst_n) // [RULE_01]
		i_powerdown_event |=> o_powerdown_status_flag)
		else $error("powerdown event lost");
endmodule // wdt_preclear_cpl
`default_nettype wire

// ### wdt_preclear_and_complement_ops_tb_top.sv
// Self-checking bench for the pre-clear pair and memory complement
`timescale 1ns/1ps
`default_nettype none
module wdt_preclear_and_complement_ops_tb_top;
	import wdt_ops_pkg::*;
	logic              clk, rst_n, pf, ps, tev, pev, cv, we;
	logic              wclr, tflag, pflag, crdy, cdone, zf;
	logic [ADDR_W-1:0] ca, ma;
	logic [DATA_W-1:0] md, rd;
	int                mismatches, n_checks;

	////////////////////////////////////////////////////////////////
	// Clock and device
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	wdt_preclear_cpl u_dut (
		.i_clk                   (clk),
		.i_rst_n                 (rst_n),
		.i_preclear_first        (pf),
		.i_preclear_second       (ps),
		.i_timeout_event         (tev),
		.i_powerdown_event       (pev),
		.o_watchdog_clear        (wclr),
		.o_timeout_status_flag   (tflag),
		.o_powerdown_status_flag (pflag),
		.i_cpl_valid             (cv),
		.i_cpl_addr              (ca),
		.o_cpl_ready             (crdy),
		.o_cpl_done              (cdone),
		.o_zero_flag             (zf),
		.i_mem_we                (we),
		.i_mem_addr              (ma),
		.i_mem_wdata             (md),
		.o_mem_rdata             (rd)
	);

	////////////////////////////////////////////////////////////////
	// Compare, count and close
	task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic finish_test();
		if (mismatches == 0 && n_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Scenarios
	// Raise both status flags with a one-cycle event
	task automatic raise_flags();
		tev = 1'b1;
		pev = 1'b1;
		@(negedge clk);
		tev = 1'b0;
		pev = 1'b0;
	endtask

	// Issue a pre-clear pair pattern and judge its effect
	task automatic preclear(input logic f, input logic s, input logic eff);
		raise_flags();
		pf = f;
		ps = s;
		@(negedge clk);
		pf = 1'b0;
		ps = 1'b0;
		chk("watchdog_clear", wclr, eff);
		chk("timeout_flag", tflag, !eff);
		chk("powerdown_flag", pflag, !eff);
		@(negedge clk);
		chk("clear_pulse_end", wclr, 1'b0);
	endtask

	// Effective first variant in the cycle of a time-out: the event wins
	task automatic clear_vs_event();
		tev = 1'b1;
		pev = 1'b1;
		@(negedge clk);
		pev = 1'b0;
		pf  = 1'b1;
		@(negedge clk);
		tev = 1'b0;
		pf  = 1'b0;
		chk("clear_with_event", wclr, 1'b1);
		chk("timeout_set_wins", tflag, 1'b1);
		chk("powerdown_cleared", pflag, 1'b0);
		@(negedge clk);
		chk("clear_pulse_end2", wclr, 1'b0);
	endtask

	// Reset in mid-run: flags and pair history return to idle
	task automatic reset_mid();
		raise_flags();
		rst_n = 1'b0;
		@(negedge clk);
		chk("mid_reset_flags", {tflag, pflag, wclr, cdone, zf}, 8'h00);
		chk("mid_reset_ready", crdy, 1'b1);
		rst_n = 1'b1;
		preclear(1'b0, 1'b1, 1'b0);
		preclear(1'b1, 1'b0, 1'b1);
	endtask

	// Write a byte, complement it in place, read it back
	task automatic complement(input logic [7:0] a, input logic [7:0] d);
		int i;
		we = 1'b1;
		ma = a;
		md = d;
		@(negedge clk);
		we = 1'b0;
		cv = 1'b1;
		ca = a;
		@(negedge clk);
		cv = 1'b0;
		chk("cpl_ready_busy", crdy, 1'b0);
		for (i = 0; i < 4 && cdone !== 1'b1; i++)
			@(negedge clk);
		if (cdone !== 1'b1)
		begin
			mismatches++;
			finish_test();
		end
		chk("zero_flag", zf, (~d == 8'h00));
		chk("cpl_ready_idle", crdy, 1'b1);
		@(negedge clk);
		chk("cpl_done_end", cdone, 1'b0);
		@(negedge clk);
		chk("complement_data", rd, ~d);
	endtask

	// Two complements back to back; the second waits out the busy cycle
	task automatic cpl_back_to_back(input logic [7:0] a1, input logic [7:0] d1,
		input logic [7:0] a2, input logic [7:0] d2);
		we = 1'b1;
		ma = a1;
		md = d1;
		@(negedge clk);
		ma = a2;
		md = d2;
		@(negedge clk);
		we = 1'b0;
		cv = 1'b1;
		ca = a1;
		@(negedge clk);
		ca = a2;
		chk("b2b_ready_busy", crdy, 1'b0);
		@(negedge clk);
		chk("b2b_done_first", cdone, 1'b1);
		chk("b2b_zero_first", zf, (~d1 == 8'h00));
		chk("b2b_ready_again", crdy, 1'b1);
		@(negedge clk);
		cv = 1'b0;
		chk("b2b_done_gap", cdone, 1'b0);
		@(negedge clk);
		ma = a1;
		chk("b2b_done_second", cdone, 1'b1);
		chk("b2b_zero_second", zf, (~d2 == 8'h00));
		@(negedge clk);
		ma = a2;
		chk("b2b_data_first", rd, ~d1);
		@(negedge clk);
		chk("b2b_data_second", rd, ~d2);
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{rst_n, pf, ps, tev, pev, cv, we} = '0;
		ca = 8'h00;
		ma = 8'h00;
		md = 8'h00;
		mismatches = 0;
		n_checks = 0;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		chk("reset_flags", {tflag, pflag, wclr, cdone, zf}, 8'h00);
		chk("reset_ready", crdy, 1'b1);
		preclear(1'b1, 1'b0, 1'b0);
		preclear(1'b1, 1'b0, 1'b0);
		preclear(1'b0, 1'b1, 1'b1);
		preclear(1'b0, 1'b1, 1'b0);
		preclear(1'b1, 1'b1, 1'b0);
		preclear(1'b1, 1'b0, 1'b1);
		preclear(1'b0, 1'b1, 1'b1);
		clear_vs_event();
		complement(8'h10, 8'hff);
		reset_mid();
		complement(8'hff, 8'h00);
		complement(8'h00, 8'h5a);
		cpl_back_to_back(8'h20, 8'hff, 8'h21, 8'h3c);
		finish_test();
	end
endmodule // wdt_preclear_and_complement_ops_tb_top
`default_nettype wire
